// *** core/mtr_pkg.sv ***
// Purpose: shared constants of the register-access frame server
// Assumes: frames arrive as TCP payload bytes, one frame per request
// Notes:   start numbers are reference numbers less the reference base
package mtr_pkg;
   // tcp ports served
   localparam logic [15:0] PORT_REGS     = 16'h01F6;
   localparam logic [15:0] PORT_ACQ      = 16'h8724;
   // header layout, byte positions from frame start
   localparam logic [11:0] POS_TID_HI    = 12'h000;
   localparam logic [11:0] POS_TID_LO    = 12'h001;
   localparam logic [11:0] POS_PID_HI    = 12'h002;
   localparam logic [11:0] POS_PID_LO    = 12'h003;
   localparam logic [11:0] POS_LEN_HI    = 12'h004;
   localparam logic [11:0] POS_LEN_LO    = 12'h005;
   localparam logic [11:0] POS_UNIT      = 12'h006;
   localparam logic [11:0] POS_FUNC      = 12'h007;
   localparam logic [11:0] POS_A_HI      = 12'h008;
   localparam logic [11:0] POS_A_LO      = 12'h009;
   localparam logic [11:0] POS_B_HI      = 12'h00A;
   localparam logic [11:0] POS_B_LO      = 12'h00B;
   localparam logic [11:0] POS_DATA      = 12'h009;
   localparam logic [11:0] MIN_FRAME     = 12'h008;
   localparam logic [15:0] LEN_BEFORE_UNIT = 16'h0006;
   localparam logic [11:0] LAST_FROM_LEN = 12'h005;
   // field values
   localparam logic [15:0] PROTO_ID      = 16'h0000;
   localparam logic [7:0]  UNIT_ID       = 8'h01;
   localparam logic [7:0]  FC_READ       = 8'h03;
   localparam logic [7:0]  FC_WRITE1     = 8'h06;
   localparam logic [7:0]  EXC_FLAG      = 8'h80;
   localparam logic [7:0]  ERR_NONE      = 8'h00;
   localparam logic [7:0]  ERR_FUNC      = 8'h01;
   localparam logic [7:0]  ERR_ADDR      = 8'h02;
   localparam logic [7:0]  ERR_COUNT     = 8'h03;
   localparam logic [15:0] REQ_LEN       = 16'h0006;
   localparam logic [15:0] ERR_RSP_LEN   = 16'h0003;
   localparam logic [15:0] WR_RSP_LEN    = 16'h0006;
   localparam logic [15:0] RD_RSP_EXTRA  = 16'h0003;
   localparam logic [15:0] MAX_READ      = 16'h0064;
   // register map
   localparam logic [15:0] REF_BASE      = 16'h9C41;
   localparam logic [15:0] INTERVAL_REF  = 16'hA3AD;
   localparam logic [15:0] INTERVAL_ADDR = INTERVAL_REF - REF_BASE;
   localparam logic [15:0] LAST_ADDR     = 16'h076C;
   localparam logic [1:0]  INTERVAL_RST  = 2'h0;
   localparam logic [15:0] INTERVAL_MAX  = 16'h0003;
   // idle connection timeout
   localparam int unsigned CLK_HZ        = 10_000_000;
   localparam int unsigned IDLE_TIME_S   = 60;
   localparam int unsigned IDLE_CYCLES   = IDLE_TIME_S * CLK_HZ;
   typedef enum logic [2:0]
   {
      ST_LISTEN = 3'b001,
      ST_JUDGE  = 3'b010,
      ST_ANSWER = 3'b100
   } mtr_state_e;
endpackage

// *** core/mtr_idle_timer.sv ***
// Purpose: drops an idle connection after a fixed quiet time
// Assumes: restart_in pulses once per received request
// Notes:   fires once per quiet spell, then waits for a restart
`timescale 1ns/1ps
`default_nettype none
module mtr_idle_timer
#(
   parameter int unsigned CYCLES = 600_000_000
)
(
   input  wire logic clk_sys_in,
   input  wire logic reset_n_in,
   input  wire logic clk_en_in,
   input  wire logic active_in,
   input  wire logic restart_in,
   output logic      expire_out
);
   logic [31:0] count_reg;
   logic        fired_reg;
   logic        expire_reg;
   wire         at_end = (count_reg == 32'(CYCLES - 1));
   wire         clear  = restart_in || !active_in;

   always_ff @(posedge clk_sys_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         count_reg  <= 32'h0000_0000;
         fired_reg  <= 1'b0;
         expire_reg <= 1'b0;
      end
      else if (clk_en_in)
      begin
         count_reg  <= clear ? 32'h0000_0000 :
                       at_end ? count_reg : 32'(count_reg + 32'h1);
         fired_reg  <= clear ? 1'b0 : (fired_reg || at_end);
         expire_reg <= !clear && at_end && !fired_reg;
      end
   end
   assign expire_out = expire_reg;
endmodule
`default_nettype wire

// *** core/mtr_server.sv ***
// Purpose: register-access frame server behind a tcp payload stream
// Assumes: tcp/ip stack outside; rx bytes carry the local port
// Notes:   one request at a time; reads of unmapped words go to
//          the external register port, the interval word is local
// Notes on behaviour
// - Read and write register requests are served on port 502.
// - Acquisition control frames on port 34596 go to a separate port.
// - Connection is dropped after 60 s without any request.
// - Frame starts with seven header bytes: tid, protocol, length, unit.
// - Response carries the request's transaction id unchanged.
// - Protocol id is zero both ways.
// - Length counts bytes from unit id to frame end.
// - Unit id 1 is required and returned.
// - First data byte is the function code, then its arguments.
// - Start number is reference number minus 40001.
// - Read answer: length 2n+3, code 03, byte count 2n, words.
// - Interval setting: 0 1 ms, 1 10 ms, 2 50 ms, 3 100 ms.
// - Device sits on a 100BASE-TX link carrying tcp/ip.
// - Bad data part: no action, reply code+80h and error 01/02/03.
// - Bad header or no connection: no action, no reply.
// - Read count above 100 is a count error.
`timescale 1ns/1ps
`default_nettype none
module mtr_server
   import mtr_pkg::*;
#(
   parameter int unsigned IDLE_LIMIT = IDLE_CYCLES,
   parameter logic [15:0] MAX_ADDR   = LAST_ADDR
)
(
   input  wire logic        clk_sys_in,
   input  wire logic        reset_n_in,
   input  wire logic        clk_en_in,
   input  wire logic        conn_up_in,
   input  wire logic [15:0] rx_port_in,
   input  wire logic        rx_valid_in,
   input  wire logic [7:0]  rx_data_in,
   input  wire logic        rx_last_in,
   output logic             rx_ready_out,
   output logic             tx_valid_out,
   output logic [7:0]       tx_data_out,
   output logic             tx_last_out,
   input  wire logic        tx_ready_in,
   output logic             conn_close_out,
   output logic             acq_req_out,
   output logic [7:0]       acq_func_out,
   output logic [15:0]      reg_rd_addr_out,
   input  wire logic [15:0] reg_rd_data_in,
   output logic             reg_wr_en_out,
   output logic [15:0]      reg_wr_addr_out,
   output logic [15:0]      reg_wr_data_out,
   output logic [1:0]       interval_sel_out
);
   mtr_state_e  state_reg;
   mtr_state_e  state_next;
   logic [11:0] cnt_reg;
   logic [15:0] port_reg;
   logic [15:0] tid_reg;
   logic [15:0] pid_reg;
   logic [15:0] len_reg;
   logic [7:0]  uid_reg;
   logic [7:0]  fc_reg;
   logic [15:0] arg_a_reg;
   logic [15:0] arg_b_reg;
   logic [7:0]  err_reg;
   logic [15:0] rsp_len_reg;
   logic [11:0] last_idx_reg;
   logic [11:0] tx_idx_reg;
   logic [7:0]  tx_data_reg;
   logic [1:0]  interval_reg;
   logic        acq_req_reg;
   logic [7:0]  acq_func_reg;
   logic        wr_en_reg;
   logic [15:0] wr_addr_reg;
   logic [15:0] wr_data_reg;

   wire st_listen = (state_reg == ST_LISTEN);
   wire st_judge  = (state_reg == ST_JUDGE);
   wire st_answer = (state_reg == ST_ANSWER);
   // the payload stream is what the 100BASE-TX tcp stack hands over
   wire rx_fire   = clk_en_in && rx_valid_in && st_listen;
   wire tx_fire   = clk_en_in && tx_ready_in && st_answer;
   wire tx_end    = tx_fire && (tx_idx_reg == last_idx_reg);

   // header judgement, taken one cycle after the last byte
   wire len_ok    = ({4'h0, cnt_reg} ==
                     16'(len_reg + LEN_BEFORE_UNIT));
   wire hdr_ok    = conn_up_in && (cnt_reg >= MIN_FRAME) && len_ok &&
                    (pid_reg == PROTO_ID) && (uid_reg == UNIT_ID);
   wire on_regs   = (port_reg == PORT_REGS);
   wire on_acq    = (port_reg == PORT_ACQ);
   wire is_rd     = (fc_reg == FC_READ);
   wire is_wr     = (fc_reg == FC_WRITE1);
   wire [16:0] end_addr = 17'({1'b0, arg_a_reg} + {1'b0, arg_b_reg}
                              - 17'h00001);
   wire cnt_bad   = (len_reg != REQ_LEN) || (is_rd && ((arg_b_reg ==
                    16'h0000) || (arg_b_reg > MAX_READ)));
   wire addr_bad  = is_rd ? (end_addr > {1'b0, MAX_ADDR}) :
                    (arg_a_reg > MAX_ADDR);
   wire [7:0] err_code = !(is_rd || is_wr) ? ERR_FUNC :
                         cnt_bad ? ERR_COUNT :
                         addr_bad ? ERR_ADDR : ERR_NONE;
   wire [15:0] rd_len  = 16'({arg_b_reg[14:0], 1'b0} + RD_RSP_EXTRA);
   wire [15:0] rsp_len = (err_code != ERR_NONE) ? ERR_RSP_LEN :
                         is_rd ? rd_len : WR_RSP_LEN;
   wire serve     = st_judge && clk_en_in && hdr_ok && on_regs;
   wire do_write  = serve && is_wr && (err_code == ERR_NONE);
   wire wr_local  = do_write && (arg_a_reg == INTERVAL_ADDR);
   // values beyond the code range are acknowledged but not stored
   wire int_ok    = (arg_b_reg <= INTERVAL_MAX);

   // response byte builder; register words leave high byte first
   wire [11:0] tx_idx_next = st_judge ? POS_TID_HI :
                             12'(tx_idx_reg + 12'h001);
   wire [11:0] word_off    = 12'(tx_idx_next - POS_DATA);
   wire [15:0] rd_addr     = 16'(arg_a_reg + {5'h00, word_off[11:1]});
   wire [15:0] rd_word     = (rd_addr == INTERVAL_ADDR) ?
                             {14'h0000, interval_reg} : reg_rd_data_in;
   wire [7:0]  err_next    = st_judge ? err_code : err_reg;
   wire [15:0] len_next    = st_judge ? rsp_len : rsp_len_reg;
   logic [7:0] byte_next;

   always_comb
   begin
      byte_next = 8'h00;
      if (tx_idx_next == POS_TID_HI)
         byte_next = tid_reg[15:8];
      else if (tx_idx_next == POS_TID_LO)
         byte_next = tid_reg[7:0];
      else if (tx_idx_next == POS_PID_HI)
         byte_next = PROTO_ID[15:8];
      else if (tx_idx_next == POS_PID_LO)
         byte_next = PROTO_ID[7:0];
      else if (tx_idx_next == POS_LEN_HI)
         byte_next = len_next[15:8];
      else if (tx_idx_next == POS_LEN_LO)
         byte_next = len_next[7:0];
      else if (tx_idx_next == POS_UNIT)
         byte_next = UNIT_ID;
      else if (tx_idx_next == POS_FUNC)
         byte_next = (err_next != ERR_NONE) ? (fc_reg | EXC_FLAG) :
                     fc_reg;
      else if (err_next != ERR_NONE)
         byte_next = err_next;
      else if (is_rd && tx_idx_next == POS_A_HI)
         byte_next = {arg_b_reg[6:0], 1'b0};
      else if (is_rd)
         byte_next = word_off[0] ? rd_word[7:0] : rd_word[15:8];
      else if (tx_idx_next == POS_A_HI)
         byte_next = arg_a_reg[15:8];
      else if (tx_idx_next == POS_A_LO)
         byte_next = arg_a_reg[7:0];
      else if (tx_idx_next == POS_B_HI)
         byte_next = arg_b_reg[15:8];
      else
         byte_next = arg_b_reg[7:0];
   end

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ST_LISTEN:
            if (rx_fire && rx_last_in)
               state_next = ST_JUDGE;
         ST_JUDGE:
            state_next = serve ? ST_ANSWER : ST_LISTEN;
         ST_ANSWER:
            if (tx_end)
               state_next = ST_LISTEN;
         default:
            state_next = ST_LISTEN;
      endcase
   end

   // frame capture, fields arrive high byte first
   always_ff @(posedge clk_sys_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         cnt_reg   <= 12'h000;
         port_reg  <= 16'h0000;
         tid_reg   <= 16'h0000;
         pid_reg   <= 16'h0000;
         len_reg   <= 16'h0000;
         uid_reg   <= 8'h00;
         fc_reg    <= 8'h00;
         arg_a_reg <= 16'h0000;
         arg_b_reg <= 16'h0000;
      end
      else if (rx_fire)
      begin
         // a long frame saturates the count and fails the length check
         cnt_reg <= (cnt_reg == 12'hFFF) ? cnt_reg :
                    12'(cnt_reg + 12'h001);
         if (cnt_reg == POS_TID_HI)
            port_reg <= rx_port_in;
         if (cnt_reg == POS_TID_HI)
            tid_reg[15:8] <= rx_data_in;
         else if (cnt_reg == POS_TID_LO)
            tid_reg[7:0] <= rx_data_in;
         else if (cnt_reg == POS_PID_HI)
            pid_reg[15:8] <= rx_data_in;
         else if (cnt_reg == POS_PID_LO)
            pid_reg[7:0] <= rx_data_in;
         else if (cnt_reg == POS_LEN_HI)
            len_reg[15:8] <= rx_data_in;
         else if (cnt_reg == POS_LEN_LO)
            len_reg[7:0] <= rx_data_in;
         else if (cnt_reg == POS_UNIT)
            uid_reg <= rx_data_in;
         else if (cnt_reg == POS_FUNC)
            fc_reg <= rx_data_in;
         else if (cnt_reg == POS_A_HI)
            arg_a_reg[15:8] <= rx_data_in;
         else if (cnt_reg == POS_A_LO)
            arg_a_reg[7:0] <= rx_data_in;
         else if (cnt_reg == POS_B_HI)
            arg_b_reg[15:8] <= rx_data_in;
         else if (cnt_reg == POS_B_LO)
            arg_b_reg[7:0] <= rx_data_in;
      end
      else if (st_judge && clk_en_in)
         cnt_reg <= 12'h000;
   end

   always_ff @(posedge clk_sys_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         state_reg    <= ST_LISTEN;
         err_reg      <= ERR_NONE;
         rsp_len_reg  <= 16'h0000;
         last_idx_reg <= 12'h000;
         tx_idx_reg   <= 12'h000;
         tx_data_reg  <= 8'h00;
      end
      else if (clk_en_in)
      begin
         state_reg <= state_next;
         if (st_judge)
         begin
            err_reg      <= err_code;
            rsp_len_reg  <= rsp_len;
            last_idx_reg <= 12'(rsp_len + {4'h0, LAST_FROM_LEN});
         end
         if (st_judge || (tx_fire && !tx_end))
         begin
            tx_idx_reg  <= tx_idx_next;
            tx_data_reg <= byte_next;
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         interval_reg <= INTERVAL_RST;
         acq_req_reg  <= 1'b0;
         acq_func_reg <= 8'h00;
         wr_en_reg    <= 1'b0;
         wr_addr_reg  <= 16'h0000;
         wr_data_reg  <= 16'h0000;
      end
      else if (clk_en_in)
      begin
         if (wr_local && int_ok)
            interval_reg <= arg_b_reg[1:0];
         acq_req_reg <= st_judge && hdr_ok && on_acq;
         if (st_judge && hdr_ok && on_acq)
            acq_func_reg <= fc_reg;
         wr_en_reg <= do_write && !wr_local;
         if (do_write)
         begin
            wr_addr_reg <= arg_a_reg;
            wr_data_reg <= arg_b_reg;
         end
      end
   end

   mtr_idle_timer #(.CYCLES(IDLE_LIMIT)) idle_timer
   (
      .clk_sys_in (clk_sys_in),
      .reset_n_in (reset_n_in),
      .clk_en_in  (clk_en_in),
      .active_in  (conn_up_in),
      .restart_in (st_judge),
      .expire_out (conn_close_out)
   );

   // handshakes follow the enable so no byte is lost while frozen
   assign rx_ready_out     = st_listen && clk_en_in;
   assign tx_valid_out     = st_answer && clk_en_in;
   assign tx_last_out      = tx_valid_out && (tx_idx_reg == last_idx_reg);
   assign tx_data_out      = tx_data_reg;
   assign reg_rd_addr_out  = rd_addr;
   assign reg_wr_en_out    = wr_en_reg;
   assign reg_wr_addr_out  = wr_addr_reg;
   assign reg_wr_data_out  = wr_data_reg;
   assign acq_req_out      = acq_req_reg;
   assign acq_func_out     = acq_func_reg;
   assign interval_sel_out = interval_reg;

   AST_TID_ECHO:
      assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
         tx_valid_out && tx_idx_reg == POS_TID_LO
         |-> tx_data_out == tid_reg[7:0])
      else $error("transaction id not echoed");
   AST_PROTO_ZERO:
      assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
         tx_valid_out && (tx_idx_reg == POS_PID_HI ||
         tx_idx_reg == POS_PID_LO) |-> tx_data_out == 8'h00)
      else $error("protocol id byte not zero");
   AST_UNIT_ONE:
      assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
         tx_valid_out && tx_idx_reg == POS_UNIT |-> tx_data_out == 8'h01)
      else $error("unit id not one");
   AST_READ_LEN:
      assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
         tx_valid_out && tx_idx_reg == POS_LEN_LO && err_reg == ERR_NONE
         && is_rd |-> tx_data_out == 8'({arg_b_reg[6:0], 1'b0} + 8'h03))
      else $error("read answer length not 2n+3");
   AST_READ_BYTES:
      assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
         tx_valid_out && tx_idx_reg == POS_A_HI && err_reg == ERR_NONE
         && is_rd |-> tx_data_out == {arg_b_reg[6:0], 1'b0})
      else $error("read byte count not 2n");
   AST_EXC_CODE:
      assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
         tx_valid_out && tx_idx_reg == POS_FUNC && err_reg != ERR_NONE
         |-> tx_data_out == (fc_reg | 8'h80) && last_idx_reg == 12'h008)
      else $error("exception answer malformed");
   AST_COUNT_ERR:
      assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
         serve && is_rd && arg_b_reg > 16'h0064
         |=> err_reg == 8'h03 ##1 (tx_valid_out || !clk_en_in))
      else $error("oversized read not a count error");
   AST_NO_ANSWER:
      assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
         st_judge && clk_en_in && !hdr_ok |=> !tx_valid_out [*2])
      else $error("answer to bad header");
   AST_INTERVAL_KEEP:
      assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
         wr_local && !int_ok |=> $stable(interval_reg))
      else $error("out of range interval stored");
   AST_ACQ_PORT:
      assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
         st_judge && clk_en_in && hdr_ok && on_acq
         |=> acq_req_out && acq_func_out == fc_reg && !tx_valid_out)
      else $error("acquisition frame not handed over");
   AST_IDLE_RESTART:
      assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
         st_judge && clk_en_in |=> !conn_close_out)
      else $error("close right after a request");
endmodule
`default_nettype wire

// *** sim/mtr_host.sv ***
// Purpose: host client model, sends request frames and sinks answers
// Assumes: the caller keeps one frame in flight
// Notes:   idle rx data shows the inverse of the last byte sent
`timescale 1ns/1ps
`default_nettype none
module mtr_host
(
   input  wire logic   clk_sys_in,
   input  wire logic   rx_ready_in,
   output logic [15:0] rx_port_out,
   output logic        rx_valid_out,
   output logic [7:0]  rx_data_out,
   output logic        rx_last_out,
   output logic        tx_ready_out
);
   initial
   begin
      rx_port_out  = 16'h0000;
      rx_valid_out = 1'b0;
      rx_data_out  = 8'h00;
      rx_last_out  = 1'b0;
      tx_ready_out = 1'b0;
   end
   // random stalls so the answer path must honour tx_ready
   always @(posedge clk_sys_in)
      tx_ready_out <= #1 ($urandom % 4) != 0;
   task automatic send(input logic [15:0] port, input logic [7:0] b[$]);
      for (int i = 0; i < b.size(); i++)
      begin
         rx_port_out  <= port;
         rx_valid_out <= 1'b1;
         rx_data_out  <= b[i];
         rx_last_out  <= (i == b.size() - 1);
         do @(posedge clk_sys_in); while (rx_ready_in !== 1'b1);
         #1;
      end
      rx_valid_out <= 1'b0;
      rx_last_out  <= 1'b0;
      rx_data_out  <= ~b[b.size() - 1];
   endtask
endmodule
`default_nettype wire

// *** sim/modbus_tcp_register_server_bench.sv ***
// Purpose: self-checking bench of the register frame server
// Assumes: short idle limit; external words read back as address^5A5A
// Notes:   expected answer bytes queue up ahead of the monitor
`timescale 1ns/1ps
`default_nettype none
module modbus_tcp_register_server_bench
   import mtr_pkg::*;
;
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_mismatch++; \
   $display("MISMATCH t=%0t got %h want %h", $time, a, e); end end
   localparam int unsigned IDLE = 2000;
   logic             clk_sys, reset_n, conn_up, rx_ready, tx_valid, tx_last;
   logic             tx_ready, conn_close, acq_req, reg_wr_en, rx_valid;
   logic             rx_last;
   logic [7:0]       rx_data, tx_data, acq_func;
   logic [15:0]      rx_port, rd_addr, wr_addr, wr_data, ivl, tid, s;
   logic [1:0]       ivl_sel;
   logic [7:0]       fr[$];
   logic [8:0]       expq[$];
   logic [8:0]       e9;
   logic [7:0]       fcs[4] = '{8'h10, 8'h46, 8'h47, 8'h00};
   int               checks, n_mismatch, n_close, n_acq, n_wr, w;
   // enable stalls only in the read tests: pulse counts and idle
   // timing below assume an enable that stays high
   logic             stall = 1'b1;
   logic             clk_en = 1'b1;
   wire logic [15:0] rd_data = rd_addr ^ 16'h5A5A;
   mtr_server #(.IDLE_LIMIT(IDLE), .MAX_ADDR(LAST_ADDR)) i_dut
   (
      .clk_sys_in(clk_sys), .reset_n_in(reset_n), .clk_en_in(clk_en),
      .conn_up_in(conn_up), .rx_port_in(rx_port), .rx_valid_in(rx_valid),
      .rx_data_in(rx_data), .rx_last_in(rx_last), .rx_ready_out(rx_ready),
      .tx_valid_out(tx_valid), .tx_data_out(tx_data),
      .tx_last_out(tx_last), .tx_ready_in(tx_ready),
      .conn_close_out(conn_close), .acq_req_out(acq_req),
      .acq_func_out(acq_func), .reg_rd_addr_out(rd_addr),
      .reg_rd_data_in(rd_data), .reg_wr_en_out(reg_wr_en),
      .reg_wr_addr_out(wr_addr), .reg_wr_data_out(wr_data),
      .interval_sel_out(ivl_sel)
   );
   mtr_host i_host
   (
      .clk_sys_in(clk_sys), .rx_ready_in(rx_ready), .rx_port_out(rx_port),
      .rx_valid_out(rx_valid), .rx_data_out(rx_data),
      .rx_last_out(rx_last), .tx_ready_out(tx_ready)
   );
   initial
   begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys)
      clk_en <= #1 !stall || (($urandom % 4) != 0);
   always @(posedge clk_sys)
   begin
      if (tx_valid === 1'b1 && tx_ready === 1'b1)
      begin
         if (expq.size() == 0)
         begin
            n_mismatch++;
            $display("MISMATCH t=%0t unexpected byte %h", $time, tx_data);
         end
         else
         begin
            e9 = expq.pop_front();
            `CHK({tx_last, tx_data}, e9)
         end
      end
      if (conn_close === 1'b1) n_close++;
      if (acq_req === 1'b1) n_acq++;
      if (reg_wr_en === 1'b1) n_wr++;
   end
   task automatic mk(input logic [15:0] p, l, input logic [7:0] u, f,
                     input logic [15:0] a, b);
      tid = $urandom;
      fr = {tid[15:8], tid[7:0], p[15:8], p[7:0], l[15:8], l[7:0], u, f,
            a[15:8], a[7:0], b[15:8], b[7:0]};
   endtask
   task automatic ex(input logic [15:0] l, input logic [7:0] f);
      expq = {expq, 9'(tid[15:8]), 9'(tid[7:0]), 9'h000, 9'h000,
              9'(l[15:8]), 9'(l[7:0]), 9'h001, 9'(f)};
   endtask
   task automatic err(input logic [7:0] f, c);
      ex(16'h0003, f | 8'h80);
      expq.push_back(9'h100 | c);
   endtask
   // the next frame waits for the whole answer, bounded
   task automatic xact(input logic [15:0] port);
      int n;
      i_host.send(port, fr);
      repeat (4) @(posedge clk_sys);
      #1;
      n = 0;
      while ((expq.size() != 0 || rx_ready !== 1'b1) && n < 2000)
      begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      if (n == 2000) `CHK(1'b0, 1'b1)
   endtask
   task automatic rd(input logic [15:0] a, n);
      mk(16'h0000, 16'h0006, 8'h01, 8'h03, a, n);
      if (n == 0 || n > 100)
         err(8'h03, 8'h03);
      else if (int'(a) + int'(n) - 1 > int'(LAST_ADDR))
         err(8'h03, 8'h02);
      else
      begin
         ex(2 * n + 3, 8'h03);
         expq.push_back(9'(2 * n));
         for (int i = 0; i < n; i++)
         begin
            s = a + i;
            s = (s == 16'h076C) ? ivl : s ^ 16'h5A5A;
            expq = {expq, 9'(s[15:8]), 9'(s[7:0])};
         end
         expq[$] = expq[$] | 9'h100;
      end
      xact(PORT_REGS);
   endtask
   task automatic wr(input logic [15:0] a, d);
      w = n_wr;
      mk(16'h0000, 16'h0006, 8'h01, 8'h06, a, d);
      if (a > LAST_ADDR)
         err(8'h06, 8'h02);
      else
      begin
         ex(16'h0006, 8'h06);
         expq = {expq, 9'(a[15:8]), 9'(a[7:0]), 9'(d[15:8]), 9'h100 | d[7:0]};
         if (a == 16'h076C && d <= 3) ivl = d;
      end
      xact(PORT_REGS);
      `CHK(ivl_sel, ivl[1:0])
      if (a != 16'h076C && a <= LAST_ADDR)
      begin
         `CHK(n_wr, w + 1)
         `CHK({wr_addr, wr_data}, {a, d})
      end
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      #(100 * 20000);
      n_mismatch++;
      end_sim();
   end
   initial
   begin
      void'($urandom(34));
      {checks, n_mismatch, n_close, n_acq, n_wr, w} = '0;
      reset_n = 1'b0;
      conn_up = 1'b1;
      ivl = 16'h0000;
      repeat (8) @(posedge clk_sys);
      #1 reset_n = 1'b1;
      rd($urandom % 16'h0700, 2);
      rd(16'h076B, 2);
      rd(16'h0000, 100);
      rd(16'h0200, 1 + $urandom % 100);
      rd(16'h076C, 2);
      rd(16'h0010, 0);
      rd(16'h0010, 101);
      stall = 1'b0;
      $display("test reads done");
      // code 4 is out of range: answered, not stored
      for (int i = 0; i < 5; i++) wr(16'h076C, i);
      rd(16'h076C, 1);
      wr(16'h0100, $urandom);
      wr(16'h076D, 16'h0001);
      $display("test writes done");
      foreach (fcs[i])
      begin
         mk(16'h0000, 16'h0006, 8'h01, fcs[i], 16'h0000, 16'h0001);
         err(fcs[i], 8'h01);
         xact(PORT_REGS);
      end
      mk(16'h0000, 16'h0007, 8'h01, 8'h03, 16'h0000, 16'h0001);
      fr.push_back(8'h00);
      err(8'h03, 8'h03);
      xact(PORT_REGS);
      $display("test data errors done");
      // each of these must stay unanswered
      mk(16'h0001, 16'h0006, 8'h01, 8'h03, 16'h0000, 16'h0001);
      xact(PORT_REGS);
      mk(16'h0000, 16'h0006, 8'h02, 8'h03, 16'h0000, 16'h0001);
      xact(PORT_REGS);
      mk(16'h0000, 16'h0007, 8'h01, 8'h03, 16'h0000, 16'h0001);
      xact(PORT_REGS);
      mk(16'h0000, 16'h0006, 8'h01, 8'h03, 16'h0000, 16'h0001);
      xact(16'h01F7);
      conn_up = 1'b0;
      xact(PORT_REGS);
      conn_up = 1'b1;
      $display("test header refusals done");
      for (int i = 1; i < 3; i++)
      begin
         w = n_acq;
         mk(16'h0000, 16'h0006, 8'h01, fcs[i], 16'h0000, 16'h0000);
         xact(PORT_ACQ);
         `CHK(n_acq, w + 1)
         `CHK(acq_func, fcs[i])
      end
      $display("test acquisition port done");
      w = n_close;
      repeat (IDLE - 10) @(posedge clk_sys);
      `CHK(n_close, w)
      repeat (20) @(posedge clk_sys);
      `CHK(n_close, w + 1)
      repeat (IDLE) @(posedge clk_sys);
      `CHK(n_close, w + 1)
      $display("test idle drop done");
      end_sim();
   end
endmodule
`default_nettype wire
